// ---- src/tccu_pkg.sv ----
// constants, types and the helper function of the timer compare/capture unit
// Overview of operation
// RQ1 - one parallel comparator per register, every cycle
// RQ2 - registers tied to port bits zero..three
// RQ3 - bit zero interrupt edge chosen by edge select
// RQ4 - bits one..three interrupt on rising edge only
// RQ5 - no mode: pin is io or interrupt input
// RQ6 - capture: pin edge sets flag, copies timer
// RQ7 - software latch toggle captures like external edge
// RQ8 - any compare mode makes pin an output
// RQ9 - mode 0: latch only from overflow, match
// RQ10 - field value 10 enables compare mode
// RQ11 - mode 0: detector fed from comparator output
// RQ12 - mode 0: overflow clears port latch
// RQ13 - mode 0: match sets port latch
// RQ14 - mode 0 edge: select zero rising, else falling
// RQ15 - mode 1: split latch, second drives pin
// RQ16 - entering mode 1 both latches hold value
// RQ17 - mode 1 match: transfer latch, set flag
// RQ18 - mode 1: flag on every match event
// RQ19 - rewritten compare value matches by plain equality
// RQ20 - registers b..d capture on rising edge only
// RQ21 - comparators b..d drive their own flags
// RQ22 - reload mode frees pin for io use
// RQ23 - edge detector sits right before flag
// RQ24 - 16-bit timer counts up, wraps from ones
package tccu_pkg;
  localparam int          TMR_W       = 16;
  localparam int          NCH         = 4;
  localparam int          AW          = 8;
  localparam logic [7:0]  ADDR_TCTRL  = 8'h00;
  localparam logic [7:0]  ADDR_CEN    = 8'h04;
  localparam logic [7:0]  ADDR_PORT   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ    = 8'h0C;
  localparam logic [7:0]  ADDR_TMR    = 8'h10;
  localparam logic [7:0]  ADDR_CMP0   = 8'h14;
  localparam logic [7:0]  ADDR_CMP1   = 8'h18;
  localparam logic [7:0]  ADDR_CMP2   = 8'h1C;
  localparam logic [7:0]  ADDR_CMP3   = 8'h20;
  localparam logic [7:0]  ADDR_PIN    = 8'h24;
  localparam int          CTRL_CMODE  = 0;
  localparam int          CTRL_EDGE   = 1;
  localparam int          CEN_FLD_W   = 2;
  localparam logic [1:0]  CEN_CAPT    = 2'h1;
  localparam logic [1:0]  CEN_CMP     = 2'h2;
  localparam logic [1:0]  CEN_RELOAD  = 2'h3;
  localparam logic [3:0]  PORT_RST    = 4'hF;
  localparam logic [15:0] TMR_MAX     = 16'hFFFF;
  localparam logic [15:0] TMR_ONE     = 16'h0001;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

  typedef enum {MODE_IO, MODE_CAPT, MODE_CMP, MODE_RELOAD} tccu_mode_e;

  typedef struct packed {
    logic edge_select_bit;
    logic compare_mode_select;
  } tccu_ctrl_s;

  // two-bit enable field to channel mode; reload only on channel zero
  function automatic tccu_mode_e tccu_decode(input logic [1:0] fld, input logic reload_ok);
    tccu_mode_e m;
    m = MODE_IO;
    case (fld)
      CEN_CAPT:   m = MODE_CAPT;
      CEN_CMP:    m = MODE_CMP;
      CEN_RELOAD: m = reload_ok ? MODE_RELOAD : MODE_IO;
      default:    m = MODE_IO;
    endcase
    return m;
  endfunction
endpackage

// ---- src/tccu_sync.sv ----
// two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
module tccu_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle level of a released, pulled-up pin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- src/tccu_edge_det.sv ----
// transition detector that sits directly in front of a request flag
`timescale 1ns/1ps
module tccu_edge_det (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  input  wire logic rise_sel,
  output logic      pulse
);
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle pin level, so no false edge follows reset
      prev_q <= 1'b1;
    end else begin
      prev_q <= din;
    end
  end

  // only a change of the selected input in the direction set by rise_sel counts, including a source switch
  assign pulse = rise_sel ? (din & ~prev_q) : (~din & prev_q);
endmodule

// ---- src/tccu_top.sv ----
// timer with four compare/capture channels, apb register slave and port pins
`timescale 1ns/1ps
module tccu_top
  import tccu_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [NCH-1:0] pin_in,
  output logic      [NCH-1:0] pin_out,
  output logic      [NCH-1:0] pin_oe
);
  tccu_ctrl_s            ctrl_q;
  logic [2*NCH-1:0]      cen_q;
  logic [NCH-1:0]        latch_a_q;
  logic [NCH-1:0]        latch_b_q;
  logic [NCH-1:0]        flag_q;
  logic [TMR_W-1:0]      tmr_q;
  logic [TMR_W-1:0]      tmr_d;
  logic [TMR_W-1:0]      cc_q [NCH];
  logic [NCH-1:0]        pin_s;
  logic [NCH-1:0]        pin_eff;
  logic [NCH-1:0]        match;
  logic [NCH-1:0]        det_in;
  logic [NCH-1:0]        det_rise;
  logic [NCH-1:0]        det_edge;
  logic [NCH-1:0]        is_m0;
  logic [NCH-1:0]        is_m1;
  logic [NCH-1:0]        is_capt;
  tccu_mode_e            mode [NCH];
  logic                  ovf;
  logic                  setup;
  logic                  wr_en;
  logic                  hit;
  logic [31:0]           rdata;
  logic [NCH-1:0]        cc_wr;

  // port bits zero..three, pin index equals channel index
  tccu_sync #(
    .W (NCH)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_s)
  ); // [RQ2]

  // ---------------------------------------------------------------- apb
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    hit   = 1'b1;
    rdata = DATA_ZERO;
    case (paddr)
      ADDR_TCTRL: rdata = {28'h000_0000, 2'h0, ctrl_q};
      ADDR_CEN:   rdata = {24'h00_0000, cen_q};
      ADDR_PORT:  rdata = {28'h000_0000, latch_a_q};
      ADDR_IRQ:   rdata = {28'h000_0000, flag_q};
      ADDR_TMR:   rdata = {16'h0000, tmr_q};
      ADDR_CMP0:  rdata = {16'h0000, cc_q[0]};
      ADDR_CMP1:  rdata = {16'h0000, cc_q[1]};
      ADDR_CMP2:  rdata = {16'h0000, cc_q[2]};
      ADDR_CMP3:  rdata = {16'h0000, cc_q[3]};
      ADDR_PIN:   rdata = {28'h000_0000, pin_s};
      default:    hit   = 1'b0;
    endcase
  end

  // zero wait states: ready always in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= DATA_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= pwrite ? DATA_ZERO : rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      cen_q  <= '0;
    end else if (wr_en) begin
      if (paddr == ADDR_TCTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (paddr == ADDR_CEN) begin
        cen_q <= pwdata[2*NCH-1:0];
      end
    end
  end

  // ---------------------------------------------------------- channels
  assign cc_wr[0] = wr_en && (paddr == ADDR_CMP0);
  assign cc_wr[1] = wr_en && (paddr == ADDR_CMP1);
  assign cc_wr[2] = wr_en && (paddr == ADDR_CMP2);
  assign cc_wr[3] = wr_en && (paddr == ADDR_CMP3);

  assign ovf = (tmr_q == TMR_MAX);

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign mode[i]    = tccu_decode(cen_q[CEN_FLD_W*i +: CEN_FLD_W], i == 0); // [RQ10] [RQ22]
    assign is_m0[i]   = (mode[i] == MODE_CMP) && !ctrl_q.compare_mode_select;
    assign is_m1[i]   = (mode[i] == MODE_CMP) && ctrl_q.compare_mode_select;
    assign is_capt[i] = (mode[i] == MODE_CAPT);
    assign match[i]   = (cc_q[i] == tmr_q); // [RQ1] [RQ19]
    // undriven pin reads as the latch, so a latch toggle acts like a pin edge
    assign pin_eff[i] = latch_a_q[i] & pin_s[i]; // [RQ5] [RQ7]
    // compare modes feed the comparator to the detector instead of the pin
    assign det_in[i]  = (mode[i] == MODE_CMP) ? match[i] : pin_eff[i]; // [RQ11] [RQ21]

    tccu_edge_det u_edge (
      .pclk     (pclk),
      .presetn  (presetn),
      .din      (det_in[i]),
      .rise_sel (det_rise[i]),
      .pulse    (det_edge[i])
    ); // [RQ23]
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      det_rise[i] = 1'b1; // [RQ4] [RQ20] [RQ21]
    end
    if (is_m1[0]) begin
      det_rise[0] = 1'b1; // [RQ18]
    end else if (is_m0[0]) begin
      det_rise[0] = ~ctrl_q.edge_select_bit; // [RQ14]
    end else begin
      det_rise[0] = ctrl_q.edge_select_bit; // [RQ3]
    end
  end

  // timer, with reload from channel zero when that channel is in reload mode
  always_comb begin
    tmr_d = tmr_q + TMR_ONE; // [RQ24]
    if (ovf && (mode[0] == MODE_RELOAD)) begin
      tmr_d = cc_q[0];
    end
    if (wr_en && (paddr == ADDR_TMR)) begin
      tmr_d = pwdata[TMR_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  // compare registers; a capture beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        cc_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (is_capt[i] && det_edge[i]) begin
          cc_q[i] <= tmr_q; // [RQ6] [RQ7] [RQ20]
        end else if (cc_wr[i]) begin
          cc_q[i] <= pwdata[TMR_W-1:0];
        end
      end
    end
  end

  // port latch, which is latch a in compare mode 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_a_q <= PORT_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (is_m0[i]) begin
          if (match[i]) begin
            latch_a_q[i] <= 1'b1; // [RQ13]
          end else if (ovf) begin
            latch_a_q[i] <= 1'b0; // [RQ12]
          end
        end else if (wr_en && (paddr == ADDR_PORT)) begin
          latch_a_q[i] <= pwdata[i]; // [RQ9]
        end
      end
    end
  end

  // latch b tracks the port latch until mode 1 splits them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_b_q <= PORT_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!is_m1[i]) begin
          latch_b_q[i] <= latch_a_q[i]; // [RQ16]
        end else if (match[i]) begin
          latch_b_q[i] <= latch_a_q[i]; // [RQ15] [RQ17]
        end
      end
    end
  end

  // request flags: write one to clear, a new edge wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      if (wr_en && (paddr == ADDR_IRQ)) begin
        flag_q <= (flag_q & ~pwdata[NCH-1:0]) | det_edge; // [RQ17] [RQ23]
      end else begin
        flag_q <= flag_q | det_edge; // [RQ6] [RQ18]
      end
    end
  end

  // pins: quasi-bidirectional io, or pushed output in compare modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (mode[i] == MODE_CMP) begin
          pin_oe[i]  <= 1'b1; // [RQ8]
          pin_out[i] <= is_m1[i] ? latch_b_q[i] : latch_a_q[i]; // [RQ15]
        end else begin
          pin_oe[i]  <= ~latch_a_q[i]; // [RQ5] [RQ22]
          pin_out[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------- checks
  for (genvar i = 0; i < NCH; i++) begin : g_chk
    chk_m0_match_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
      is_m0[i] && match[i] |=> latch_a_q[i])
      else $error("compare mode 0 match did not set the port latch");

    chk_m0_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
      is_m0[i] && ovf && !match[i] |=> !latch_a_q[i])
      else $error("compare mode 0 overflow did not clear the port latch");

    chk_m0_write_block: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
      is_m0[i] && !match[i] && !ovf |=> latch_a_q[i] == $past(latch_a_q[i]))
      else $error("port latch changed by software in compare mode 0");

    chk_m1_transfer: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
      is_m1[i] && $rose(match[i]) |=> latch_b_q[i] == $past(latch_a_q[i]) && flag_q[i])
      else $error("compare mode 1 match did not transfer latch and set flag");

    chk_m1_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
      is_m1[i] && !match[i] |=> $stable(latch_b_q[i]))
      else $error("pin latch moved without a match in compare mode 1");

    chk_cmp_drives: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
      mode[i] == MODE_CMP |=> pin_oe[i])
      else $error("pin not driven while compare mode enabled");

    chk_capture_copy: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
      is_capt[i] && det_edge[i] |=> cc_q[i] == $past(tmr_q) && flag_q[i])
      else $error("capture edge did not copy timer and set flag");

    chk_edge_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
      det_edge[i] |=> flag_q[i])
      else $error("detected edge lost instead of setting the request flag");

    chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
      !det_edge[i] && !(wr_en && paddr == ADDR_IRQ) |=> $stable(flag_q[i]))
      else $error("request flag changed without an edge or a clear");

    chk_io_pin_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
      mode[i] != MODE_CMP |=> pin_oe[i] == !$past(latch_a_q[i]) && !pin_out[i])
      else $error("io pin not released by a port latch holding one");

    chk_capt_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ20]
      is_capt[i] && !det_edge[i] && !cc_wr[i] |=> $stable(cc_q[i]))
      else $error("capture register changed without an active edge");

    chk_m0_pin_out: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
      is_m0[i] |=> pin_out[i] == $past(latch_a_q[i]) && pin_oe[i])
      else $error("compare mode 0 pin does not follow the port latch");

    chk_m1_pin_out: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
      is_m1[i] |=> pin_out[i] == $past(latch_b_q[i]) && pin_oe[i])
      else $error("compare mode 1 pin does not follow the second latch");

    chk_m1_latch_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
      is_m1[i] && wr_en && paddr == ADDR_PORT |=> latch_a_q[i] == $past(pwdata[i]))
      else $error("compare mode 1 software write missed the first latch");

    chk_cc_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ19]
      cc_wr[i] && !(is_capt[i] && det_edge[i]) |=> cc_q[i] == $past(pwdata[TMR_W-1:0]))
      else $error("compare register write did not take effect at once");
  end

  for (genvar i = 1; i < NCH; i++) begin : g_chk_rise
    chk_rise_only: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
      det_edge[i] |-> det_in[i] && !$past(det_in[i]))
      else $error("request on a falling edge of a rising-only channel");
  end

  chk_sel_edge: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
    !is_m0[0] && !is_m1[0] && det_edge[0] |-> det_in[0] == ctrl_q.edge_select_bit)
    else $error("channel zero pin request on the unselected edge");

  chk_m0_edge_sel: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    is_m0[0] && det_edge[0] |-> det_in[0] == !ctrl_q.edge_select_bit)
    else $error("compare mode 0 request on the unselected comparator edge");

  chk_tmr_count: assert property (@(posedge pclk) disable iff (!presetn) // [RQ24]
    !ovf && !(wr_en && paddr == ADDR_TMR) |=> tmr_q == $past(tmr_q) + TMR_ONE)
    else $error("timer did not advance by one");

  chk_tmr_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [RQ24]
    ovf && mode[0] != MODE_RELOAD && !(wr_en && paddr == ADDR_TMR) |=> tmr_q == '0)
    else $error("timer did not wrap to zero after all ones");

  chk_reload_free: assert property (@(posedge pclk) disable iff (!presetn) // [RQ22]
    mode[0] == MODE_RELOAD |=> pin_oe[0] == !$past(latch_a_q[0]))
    else $error("reload mode did not leave the pin to io use");

  chk_reload_value: assert property (@(posedge pclk) disable iff (!presetn) // [RQ22]
    ovf && mode[0] == MODE_RELOAD && !(wr_en && paddr == ADDR_TMR) |=> tmr_q == $past(cc_q[0]))
    else $error("timer not reloaded from channel zero on overflow");

  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("apb access phase without ready");
endmodule

// ---- tb/tccu_pins.sv ----
// port pin model: pulled-up lines, optional outside driver
`timescale 1ns/1ps
module tccu_pins
  import tccu_pkg::*;
(
  input  wire logic [NCH-1:0] pin_out,
  input  wire logic [NCH-1:0] pin_oe,
  input  wire logic [NCH-1:0] ext_en,
  input  wire logic [NCH-1:0] ext_lvl,
  output logic      [NCH-1:0] pin_in
);
  // contention between device and outside source shows unknown
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (pin_oe[i] && ext_en[i] && (pin_out[i] != ext_lvl[i]))
        pin_in[i] = 1'bx;
      else if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_lvl[i];
      else
        pin_in[i] = 1'b1;
    end
  end
endmodule

// ---- tb/tb_timer_compare_capture_unit.sv ----
// self-checking bench for the timer compare/capture unit
`timescale 1ns/1ps
module tb_timer_compare_capture_unit
  import tccu_pkg::*;
;
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic        err;
  } tccu_note_s;

  logic           pclk = 1'b0;
  logic           presetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [AW-1:0]  paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic [NCH-1:0] pin_in;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] pin_oe;
  logic [NCH-1:0] ext_en;
  logic [NCH-1:0] ext_lvl;
  logic [15:0]    v;
  int             bad_count;
  int             checked;
  tccu_note_s     notes[$];

  always #2 pclk = ~pclk;

  tccu_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  tccu_pins pins (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("counts: checked=%0d bad=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives psel twice at once
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi, input logic err);
    notes.push_back('{lo, hi, err});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // read results compared against oldest note
  always @(posedge pclk) begin
    tccu_note_s n;
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      check({31'd0, (prdata >= n.lo) && (prdata <= n.hi)}, 32'h0000_0001);
      check({31'd0, pslverr}, {31'd0, n.err});
    end
  end

  initial begin
    #40000;
    $display("MISMATCH t=%0t watchdog expired", $time);
    bad_count++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr     = '0;
    pwdata    = '0;
    ext_en    = '0;
    ext_lvl   = '0;
    presetn   = 1'b0;
    bad_count = 0;
    checked   = 0;
    void'($urandom(89));
    v = 16'h2000 + 16'($urandom_range(4095));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_PORT, 32'h0000_000F, 32'h0000_000F, 1'b0);
    rd(ADDR_CEN, 32'h0000_0000, 32'h0000_0000, 1'b0);
    rd(8'h28, 32'h0000_0000, 32'h0000_0000, 1'b1);
    rd(ADDR_PIN, 32'h0000_000F, 32'h0000_000F, 1'b0);
    check({28'd0, pin_oe}, 32'h0000_0000);
    check({28'd0, pin_out}, 32'h0000_0000);
    $display("test reset done");
    // io mode edges from the outside source, then from a port latch toggle on channel two
    ext_en  <= 4'hF;
    ext_lvl <= 4'hF;
    repeat (8) @(posedge pclk);
    ext_lvl <= 4'h0;
    repeat (8) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_0001, 32'h0000_0001, 1'b0);
    ext_lvl <= 4'hF;
    repeat (8) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_000F, 32'h0000_000F, 1'b0);
    wr(ADDR_IRQ, 32'h0000_000F);
    wr(ADDR_TCTRL, 32'h0000_0002);
    ext_lvl <= 4'h0;
    repeat (8) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_0000, 32'h0000_0000, 1'b0);
    ext_lvl <= 4'hF;
    repeat (8) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_000F, 32'h0000_000F, 1'b0);
    ext_en <= 4'h0;
    wr(ADDR_IRQ, 32'h0000_000F);
    wr(ADDR_PORT, 32'h0000_000B);
    @(posedge pclk);
    check({28'd0, pin_oe}, 32'h0000_0004);
    wr(ADDR_PORT, 32'h0000_000F);
    repeat (8) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_0004, 32'h0000_0004, 1'b0);
    wr(ADDR_IRQ, 32'h0000_000F);
    $display("test io edges done");
    // capture on channels zero and one
    wr(ADDR_CEN, 32'h0000_0005);
    wr(ADDR_TMR, 32'h0000_1000);
    wr(ADDR_PORT, 32'h0000_000E);
    wr(ADDR_PORT, 32'h0000_000F);
    repeat (8) @(posedge pclk);
    rd(ADDR_CMP0, 32'h0000_1004, 32'h0000_1010, 1'b0);
    rd(ADDR_IRQ, 32'h0000_0001, 32'h0000_0001, 1'b0);
    ext_en  <= 4'h2;
    ext_lvl <= 4'h0;
    repeat (8) @(posedge pclk);
    rd(ADDR_CMP1, 32'h0000_0000, 32'h0000_0000, 1'b0);
    ext_lvl <= 4'h2;
    repeat (8) @(posedge pclk);
    rd(ADDR_CMP1, 32'h0000_1020, 32'h0000_1080, 1'b0);
    rd(ADDR_IRQ, 32'h0000_0003, 32'h0000_0003, 1'b0);
    ext_en <= 4'h0;
    wr(ADDR_CEN, 32'h0000_0000);
    wr(ADDR_IRQ, 32'h0000_000F);
    $display("test capture done");
    // compare mode 0 on channels zero and one
    wr(ADDR_TCTRL, 32'h0000_0000);
    wr(ADDR_CMP0, {16'd0, v});
    wr(ADDR_CMP1, {16'd0, v});
    wr(ADDR_CEN, 32'h0000_000A);
    @(posedge pclk);
    check({30'd0, pin_oe[1:0]}, 32'h0000_0003);
    wr(ADDR_TMR, 32'h0000_FFF0);
    repeat (30) @(posedge pclk);
    rd(ADDR_PORT, 32'h0000_000C, 32'h0000_000C, 1'b0);
    wr(ADDR_IRQ, 32'h0000_000F);
    wr(ADDR_PORT, 32'h0000_000F);
    rd(ADDR_PORT, 32'h0000_000C, 32'h0000_000C, 1'b0);
    wr(ADDR_TMR, {16'd0, v - 16'd20});
    repeat (30) @(posedge pclk);
    rd(ADDR_PORT, 32'h0000_000F, 32'h0000_000F, 1'b0);
    rd(ADDR_IRQ, 32'h0000_0003, 32'h0000_0003, 1'b0);
    check({30'd0, pin_out[1:0]}, 32'h0000_0003);
    wr(ADDR_TCTRL, 32'h0000_0002);
    wr(ADDR_IRQ, 32'h0000_000F);
    wr(ADDR_CEN, 32'h0000_0000);
    repeat (8) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_0003, 32'h0000_0003, 1'b0);
    $display("test compare mode 0 done");
    // compare mode 1 on channel two
    wr(ADDR_TCTRL, 32'h0000_0001);
    wr(ADDR_CMP2, {16'd0, v});
    wr(ADDR_CEN, 32'h0000_0020);
    wr(ADDR_IRQ, 32'h0000_000F);
    check({30'd0, pin_oe[2], pin_out[2]}, 32'h0000_0003);
    wr(ADDR_PORT, 32'h0000_000B);
    repeat (4) @(posedge pclk);
    check({31'd0, pin_out[2]}, 32'h0000_0001);
    rd(ADDR_PORT, 32'h0000_000B, 32'h0000_000B, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_TMR, {16'd0, v - 16'd20});
      repeat (30) @(posedge pclk);
      check({31'd0, pin_out[2]}, 32'h0000_0000);
      rd(ADDR_IRQ, 32'h0000_0004, 32'h0000_0004, 1'b0);
      wr(ADDR_IRQ, 32'h0000_000F);
    end
    wr(ADDR_TMR, {16'd0, v + 16'd100});
    wr(ADDR_CMP2, {16'd0, v + 16'd50});
    repeat (30) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_0000, 32'h0000_0000, 1'b0);
    wr(ADDR_CMP2, {16'd0, v + 16'd200});
    repeat (120) @(posedge pclk);
    rd(ADDR_IRQ, 32'h0000_0004, 32'h0000_0004, 1'b0);
    $display("test compare mode 1 done");
    // reload on channel zero, plain wrap without it
    wr(ADDR_CEN, 32'h0000_0003);
    wr(ADDR_CMP0, 32'h0000_FF00);
    wr(ADDR_TMR, 32'h0000_FFFC);
    repeat (6) @(posedge pclk);
    rd(ADDR_TMR, 32'h0000_FF00, 32'h0000_FF08, 1'b0);
    check({31'd0, pin_oe[0]}, 32'h0000_0000);
    wr(ADDR_CEN, 32'h0000_0000);
    wr(ADDR_TMR, 32'h0000_FFFE);
    repeat (4) @(posedge pclk);
    rd(ADDR_TMR, 32'h0000_0000, 32'h0000_0008, 1'b0);
    $display("test reload and wrap done");
    repeat (5) @(posedge pclk);
    wrap_up();
  end
endmodule
